// [core/ttyrs_bit_timer.v]
// Purpose : Bit time divider giving mid-bit and end-of-bit enable pulses.
// Assumes : Single clock; restart aligns the bit grid to a start edge.
// Notes   : Divisor is chosen from the rate code and the clock rate parameter.
`timescale 1ns/100ps
`include "ttyrs_defs.vh"

module ttyrs_bit_timer #(
  parameter P_CLK_HZ = `TTYRS_CLK_HZ
) (
  // Clock and reset
  input  wire                    i_clk,
  input  wire                    i_rst_sync_b,
  // Control
  input  wire [3:0]              i_rate_sel,
  input  wire                    i_restart,
  // Enables
  output wire                    o_half,
  output wire                    o_full
);

  reg  [`TTYRS_DIV_W-1:0] cnt_reg;
  reg  [31:0]             div_full;
  wire [`TTYRS_DIV_W-1:0] div;
  wire [`TTYRS_DIV_W-1:0] half;

  always @* begin
    case (i_rate_sel)
      `TTYRS_RATE_9600: div_full = P_CLK_HZ / 9600;
      `TTYRS_RATE_4800: div_full = P_CLK_HZ / 4800;
      `TTYRS_RATE_2400: div_full = P_CLK_HZ / 2400;
      `TTYRS_RATE_1200: div_full = P_CLK_HZ / 1200;
      `TTYRS_RATE_600:  div_full = P_CLK_HZ / 600;
      `TTYRS_RATE_300:  div_full = P_CLK_HZ / 300;
      `TTYRS_RATE_200:  div_full = P_CLK_HZ / 200;
      `TTYRS_RATE_150:  div_full = P_CLK_HZ / 150;
      `TTYRS_RATE_110:  div_full = P_CLK_HZ / 110;
      `TTYRS_RATE_100:  div_full = P_CLK_HZ / 100;
      `TTYRS_RATE_75:   div_full = P_CLK_HZ / 75;
      default:          div_full = P_CLK_HZ / 50;
    endcase
  end

  // The slowest rate at the nominal clock still fits the counter width.
  assign div    = div_full[`TTYRS_DIV_W-1:0];

  assign half   = {1'b0, div[`TTYRS_DIV_W-1:1]};
  assign o_full = (cnt_reg == div - 1'b1) && !i_restart;
  assign o_half = (cnt_reg == half) && !i_restart;

  always @(posedge i_clk or negedge i_rst_sync_b) begin
    if (!i_rst_sync_b) begin
      cnt_reg <= {`TTYRS_DIV_W{1'b0}};
    end else if (i_restart || o_full) begin
      cnt_reg <= {`TTYRS_DIV_W{1'b0}};
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

endmodule // ttyrs_bit_timer

// [core/ttyrs_top.v]
// Purpose : Receive status sequencing and two latched switch outputs of a serial adapter.
// Assumes : Serial line and command strobes are synchronous to i_clk; mark is logic one.
// Notes   : Transmit path lives outside; it reports its start bit with i_tx_start.
`timescale 1ns/100ps
`include "ttyrs_defs.vh"

// Summary of operation
// [RULE1] Receive spans nine bit times to interrupt
// [RULE2] Sender spaces characters by two stop-bit times
// [RULE3] Normal receive posts an attention interrupt
// [RULE4] Late service flags overrun, posts code 2
// [RULE5] Code 2 needs acceptance only, no Read
// [RULE6] Prompt service after code 2 yields code 4
// [RULE7] Very long delay across overruns yields code 6
// [RULE8] Read byte is 0001 000X
// [RULE9] Read bit 7 set closes first output
// [RULE10] Read bit 7 clear opens first output
// [RULE11] Any reset opens first output
// [RULE12] Read updates only on codes 1, 5, 7
// [RULE13] Commands never answered with 2, 4, 6
// [RULE14] Read changes fall between stop and start
// [RULE15] Write byte is 0101 000X
// [RULE16] Write bit 7 set closes second output
// [RULE17] Write bit 7 clear opens second output
// [RULE18] Any reset opens second output
// [RULE19] Write updates only on codes 1, 7
// [RULE20] Second output changes within 0.2 us of start
// [RULE21] Power-on clears all, shift register to ones
// [RULE22] Each output one flip-flop, one means closed
module ttyrs_top #(
  parameter P_CLK_HZ = `TTYRS_CLK_HZ
) (
  // Clock and power-on reset
  input  wire       i_clk,
  input  wire       i_rst_b,
  // System and device resets
  input  wire       i_sys_reset,
  input  wire       i_dev_reset,
  // Serial receive line and rate
  input  wire       i_rx_line,
  input  wire [3:0] i_rate_sel,
  // Interrupt handshake
  input  wire       i_irq_accept,
  output wire       o_irq_req,
  output wire [2:0] o_irq_cc,
  output wire [7:0] o_rx_data,
  output wire       o_rx_active,
  // Commands
  input  wire       i_cmd_strobe,
  input  wire [7:0] i_cmd_byte,
  input  wire       i_data_check,
  input  wire       i_tx_busy,
  input  wire       i_tx_start,
  output wire       o_cmd_ack,
  output wire [2:0] o_cmd_cc,
  // Switch outputs
  output wire       o_rctl_closed,
  output wire       o_wctl_closed
);

  localparam S_IDLE  = 2'b00;
  localparam S_START = 2'b01;
  localparam S_DATA  = 2'b10;

  // --------------------------------------------------------------------------
  // Reset release
  // --------------------------------------------------------------------------
  reg rst_meta_reg;
  reg rst_sync_reg;

  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  wire soft_reset = i_sys_reset | i_dev_reset;

  // --------------------------------------------------------------------------
  // Receiver
  // --------------------------------------------------------------------------
  reg  [1:0] state_reg;
  reg  [3:0] bit_cnt_reg;
  reg  [7:0] shift_reg;
  reg  [7:0] data_reg;
  reg        line_prev_reg;
  wire       bit_half;
  wire       bit_full;
  wire       start_edge = (state_reg == S_IDLE) && line_prev_reg && !i_rx_line;
  wire       complete   = (state_reg == S_DATA) && bit_full && (bit_cnt_reg == `TTYRS_RX_BITS - 1);

  ttyrs_bit_timer #(
    .P_CLK_HZ     (P_CLK_HZ)
  ) u_bit_timer (
    .i_clk        (i_clk),
    .i_rst_sync_b (rst_sync_reg),
    .i_rate_sel   (i_rate_sel),
    .i_restart    (start_edge),
    .o_half       (bit_half),
    .o_full       (bit_full)
  );

  always @(posedge i_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      state_reg     <= S_IDLE;
      bit_cnt_reg   <= 4'h0;
      shift_reg     <= `TTYRS_SHIFT_RST;                     // [RULE21]
      data_reg      <= `TTYRS_BYTE_RST;
      line_prev_reg <= 1'b1;
    end else begin
      line_prev_reg <= i_rx_line;
      case (state_reg)
        S_IDLE: begin
          bit_cnt_reg <= 4'h0;
          if (start_edge) begin
            state_reg <= S_START;
          end
        end
        S_START: begin
          // A start bit gone high by mid-bit is line noise, not a character.
          if (bit_half) begin
            state_reg <= i_rx_line ? S_IDLE : S_DATA;
          end
        end
        S_DATA: begin
          if (bit_half) begin
            shift_reg <= {i_rx_line, shift_reg[7:1]};
          end
          if (bit_full) begin
            bit_cnt_reg <= bit_cnt_reg + 1'b1;
          end
          if (complete) begin
            data_reg  <= shift_reg;                            // [RULE1]
            state_reg <= S_IDLE;
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Interrupt status sequencing
  // --------------------------------------------------------------------------
  reg        posted_reg;
  reg        irq_req_reg;
  reg  [2:0] irq_cc_reg;
  reg        acc_reg;
  reg        rd_reg;
  reg        ovr_reg;
  reg        long_reg;
  reg        rec_reg;
  reg        valid_reg;
  reg        cmd_ack_reg;
  reg  [2:0] cmd_cc_reg;
  reg        rctl_reg;
  reg        wctl_reg;
  reg        wpend_reg;
  reg        wval_reg;
  reg  [3:0] win_reg;
  reg  [2:0] cmd_cc_next;
  reg  [2:0] post_cc_next;

  wire is_read  = (i_cmd_byte[`TTYRS_OP_HI:`TTYRS_OP_LO] == `TTYRS_OP_READ) &&
                  (i_cmd_byte[`TTYRS_ZERO_HI:`TTYRS_ZERO_LO] == 3'h0);          // [RULE8]
  wire is_write = (i_cmd_byte[`TTYRS_OP_HI:`TTYRS_OP_LO] == `TTYRS_OP_WRITE) &&
                  (i_cmd_byte[`TTYRS_ZERO_HI:`TTYRS_ZERO_LO] == 3'h0);          // [RULE15]
  wire ctl_bit  = i_cmd_byte[`TTYRS_CTL_BIT];
  wire exc_cc   = (irq_cc_reg == `TTYRS_CC_OVERRUN) || (irq_cc_reg == `TTYRS_CC_LONG);
  wire accepted = acc_reg || (irq_req_reg && i_irq_accept);
  wire data_rd  = i_cmd_strobe && is_read && (cmd_cc_next == `TTYRS_CC_ACCEPT);
  wire was_read = rd_reg || data_rd;
  // An exception code is serviced by acceptance alone; a data code needs the Read too.
  wire serviced = accepted && (exc_cc || was_read);                              // [RULE5]

  // Answers are drawn only from 1, 3, 5 and 7.
  always @* begin
    if (!is_read && !is_write) begin
      cmd_cc_next = `TTYRS_CC_REJECT;                                            // [RULE13]
    end else if (i_data_check) begin
      cmd_cc_next = `TTYRS_CC_DCHECK;
    end else if (is_read ? !valid_reg : i_tx_busy) begin
      cmd_cc_next = `TTYRS_CC_BUSY;
    end else begin
      cmd_cc_next = `TTYRS_CC_ACCEPT;
    end
  end

  always @* begin
    if (ovr_reg) begin
      post_cc_next = long_reg ? `TTYRS_CC_LONG : `TTYRS_CC_OVERRUN;             // [RULE4] [RULE7]
    end else if (rec_reg) begin
      post_cc_next = `TTYRS_CC_RECOVER;                                          // [RULE6]
    end else begin
      post_cc_next = `TTYRS_CC_ATTN;                                             // [RULE3]
    end
  end

  always @(posedge i_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      posted_reg  <= 1'b0;
      irq_req_reg <= 1'b0;
      irq_cc_reg  <= `TTYRS_CC_ATTN;
      acc_reg     <= 1'b0;
      rd_reg      <= 1'b0;
      ovr_reg     <= 1'b0;
      long_reg    <= 1'b0;
      rec_reg     <= 1'b0;
      valid_reg   <= 1'b0;
    end else if (soft_reset) begin
      posted_reg  <= 1'b0;
      irq_req_reg <= 1'b0;
      irq_cc_reg  <= `TTYRS_CC_ATTN;
      acc_reg     <= 1'b0;
      rd_reg      <= 1'b0;
      ovr_reg     <= 1'b0;
      long_reg    <= 1'b0;
      rec_reg     <= 1'b0;
      valid_reg   <= 1'b0;
    end else begin
      if (irq_req_reg && i_irq_accept) begin
        irq_req_reg <= 1'b0;
        acc_reg     <= 1'b1;
      end
      if (data_rd) begin
        rd_reg    <= 1'b1;
        valid_reg <= 1'b0;
      end
      // The next start edge closes the service gap of the last posting.
      if (start_edge && posted_reg) begin
        if (!serviced) begin
          ovr_reg  <= 1'b1;                                                      // [RULE4]
          long_reg <= exc_cc && !accepted;                                       // [RULE7]
        end else begin
          rec_reg  <= exc_cc && was_read;                                        // [RULE6]
        end
      end
      // Completion wins over a same-cycle accept or read of the old posting.
      if (complete) begin
        posted_reg  <= 1'b1;
        irq_req_reg <= 1'b1;                                                     // [RULE3]
        irq_cc_reg  <= post_cc_next;
        acc_reg     <= 1'b0;
        rd_reg      <= 1'b0;
        ovr_reg     <= 1'b0;
        long_reg    <= 1'b0;
        rec_reg     <= 1'b0;
        valid_reg   <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Command answers and switch outputs
  // --------------------------------------------------------------------------
  // The Read control follows the command on its accepting edge; Reads are
  // issued inside the receive interrupt service, which keeps its changes
  // between a stop bit and the next start bit unless overrun stretches that.
  always @(posedge i_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      cmd_ack_reg <= 1'b0;
      cmd_cc_reg  <= `TTYRS_CC_ATTN;
      rctl_reg    <= 1'b0;
      wpend_reg   <= 1'b0;
      wval_reg    <= 1'b0;
    end else begin
      cmd_ack_reg <= i_cmd_strobe;
      if (i_cmd_strobe) begin
        cmd_cc_reg <= cmd_cc_next;
      end
      if (soft_reset) begin
        rctl_reg  <= 1'b0;                                                       // [RULE11]
        wpend_reg <= 1'b0;
        wval_reg  <= 1'b0;
      end else if (i_cmd_strobe && is_read &&
                   (cmd_cc_next == `TTYRS_CC_BUSY || cmd_cc_next == `TTYRS_CC_DCHECK ||
                    cmd_cc_next == `TTYRS_CC_ACCEPT)) begin                     // [RULE12] [RULE14]
        rctl_reg <= ctl_bit;                                                     // [RULE9] [RULE10] [RULE22]
      end else if (i_cmd_strobe && is_write &&
                   (cmd_cc_next == `TTYRS_CC_BUSY || cmd_cc_next == `TTYRS_CC_ACCEPT)) begin // [RULE19]
        wpend_reg <= 1'b1;
        wval_reg  <= ctl_bit;
      end else if (wpend_reg && (i_tx_start || win_reg != 4'h0)) begin
        wpend_reg <= 1'b0;
      end
    end
  end

  // The Write control may move only in a short window from the start bit edge,
  // so a write is held pending until the transmitter begins a character.
  wire [31:0] win_load = `TTYRS_WCTL_WIN_CYC - 1;

  always @(posedge i_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      win_reg  <= 4'h0;
      wctl_reg <= 1'b0;
    end else begin
      if (i_tx_start) begin
        win_reg <= win_load[3:0];
      end else if (win_reg != 4'h0) begin
        win_reg <= win_reg - 1'b1;
      end
      if (soft_reset) begin
        wctl_reg <= 1'b0;                                                        // [RULE18]
      end else if (wpend_reg && (i_tx_start || win_reg != 4'h0)) begin         // [RULE20]
        wctl_reg <= wval_reg;                                                    // [RULE16] [RULE17] [RULE22]
      end
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign o_irq_req     = irq_req_reg;
  assign o_irq_cc      = irq_cc_reg;
  assign o_rx_data     = data_reg;
  assign o_rx_active   = (state_reg != S_IDLE);
  assign o_cmd_ack     = cmd_ack_reg;
  assign o_cmd_cc      = cmd_cc_reg;
  assign o_rctl_closed = rctl_reg;
  assign o_wctl_closed = wctl_reg;

endmodule // ttyrs_top

// [inc/ttyrs_defs.vh]
// Purpose : Shared constants of the serial adapter receive status and switch outputs.
// Assumes : Included by bare name from every design file of the block.
// Notes   : Definitions only.
`ifndef TTYRS_DEFS_VH
`define TTYRS_DEFS_VH

// ----------------------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------------------
`define TTYRS_CLK_HZ        20000000
`define TTYRS_RX_BITS       9
`define TTYRS_WCTL_WIN_NS   200
`define TTYRS_WCTL_WIN_CYC  ((`TTYRS_WCTL_WIN_NS * (`TTYRS_CLK_HZ / 1000000)) / 1000)
`define TTYRS_DIV_W         19

// ----------------------------------------------------------------------------
// Bit rate selection codes
// ----------------------------------------------------------------------------
`define TTYRS_RATE_9600     4'h0
`define TTYRS_RATE_4800     4'h1
`define TTYRS_RATE_2400     4'h2
`define TTYRS_RATE_1200     4'h3
`define TTYRS_RATE_600      4'h4
`define TTYRS_RATE_300      4'h5
`define TTYRS_RATE_200      4'h6
`define TTYRS_RATE_150      4'h7
`define TTYRS_RATE_110      4'h8
`define TTYRS_RATE_100      4'h9
`define TTYRS_RATE_75       4'hA
`define TTYRS_RATE_50       4'hB

// ----------------------------------------------------------------------------
// Command byte layout (vector bit 7 is the leading bit 0 of the byte)
// ----------------------------------------------------------------------------
`define TTYRS_OP_HI         7
`define TTYRS_OP_LO         4
`define TTYRS_OP_READ       4'h1
`define TTYRS_OP_WRITE      4'h5
`define TTYRS_ZERO_HI       3
`define TTYRS_ZERO_LO       1
`define TTYRS_CTL_BIT       0

// ----------------------------------------------------------------------------
// Condition codes
// ----------------------------------------------------------------------------
`define TTYRS_CC_ATTN       3'h0
`define TTYRS_CC_BUSY       3'h1
`define TTYRS_CC_OVERRUN    3'h2
`define TTYRS_CC_REJECT     3'h3
`define TTYRS_CC_RECOVER    3'h4
`define TTYRS_CC_DCHECK     3'h5
`define TTYRS_CC_LONG       3'h6
`define TTYRS_CC_ACCEPT     3'h7

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define TTYRS_SHIFT_RST     8'hFF
`define TTYRS_BYTE_RST      8'h00

`endif

// [tb/tb_top.sv]
// Purpose : Self-checking bench for receive codes and the two switch outputs.
// Assumes : Clock rate lowered to 96 kHz so one bit at code 0 lasts 10 cycles.
// Notes   : Service happens between characters; skipping it provokes overrun.
`timescale 1ns/100ps
module tb_top;
  localparam P_CLK_HZ = 96000;
  localparam DIV = P_CLK_HZ / 9600;
  localparam LIMIT = 20000;
  reg clk, rst_b, sys_reset, dev_reset, irq_accept, cmd_strobe, data_check, tx_busy, tx_start, go;
  reg [3:0] rate_sel;
  reg [7:0] cmd_byte, tx_data, b;
  reg [2:0] prev_cc;
  reg acc_f, rd_f, c;
  wire rx_line, snd_busy, irq_req, rx_active, cmd_ack, rctl, wctl;
  wire [2:0] irq_cc, cmd_cc;
  wire [7:0] rx_data;
  integer fails, n_tests, cycles, i;

  ttyrs_top #(.P_CLK_HZ(P_CLK_HZ)) i_dut (
    .i_clk(clk), .i_rst_b(rst_b), .i_sys_reset(sys_reset), .i_dev_reset(dev_reset), .i_rx_line(rx_line),
    .i_rate_sel(rate_sel), .i_irq_accept(irq_accept), .o_irq_req(irq_req), .o_irq_cc(irq_cc),
    .o_rx_data(rx_data), .o_rx_active(rx_active), .i_cmd_strobe(cmd_strobe), .i_cmd_byte(cmd_byte),
    .i_data_check(data_check), .i_tx_busy(tx_busy), .i_tx_start(tx_start), .o_cmd_ack(cmd_ack),
    .o_cmd_cc(cmd_cc), .o_rctl_closed(rctl), .o_wctl_closed(wctl));
  ttyrs_tb_sender #(.P_DIV(DIV)) i_snd (.i_clk(clk), .i_go(go), .i_data(tx_data), .o_line(rx_line), .o_busy(snd_busy));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Code the next completion should post, from the last code and its service.
  function [2:0] exp_cc(input [2:0] p, input a, input r);
    begin
      if (a && (r || p[1])) exp_cc = (p[1] && r) ? 3'h4 : 3'h0;
      else exp_cc = (p[1] && !a) ? 3'h6 : 3'h2;
    end
  endfunction

  task test_done;
    begin
      $display("Comparisons %0d, mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
    end
  endtask

  task chk(input [7:0] seen, input [7:0] exp);
    begin
      n_tests = n_tests + 1;
      if (seen !== exp) begin
        fails = fails + 1;
        $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask

  task cmd(input [7:0] v, input dchk, input busy, input [2:0] exp);
    integer w;
    begin
      @(posedge clk); #1;
      cmd_strobe = 1'b1; cmd_byte = v; data_check = dchk; tx_busy = busy;
      @(posedge clk); #1;
      cmd_strobe = 1'b0;
      w = 0;
      while (cmd_ack !== 1'b1 && w < 4) begin
        @(posedge clk); #1;
        w = w + 1;
      end
      chk(cmd_cc, exp);
    end
  endtask

  task read(input ctl, input dchk, input [2:0] exp);
    begin
      cmd({7'h08, ctl}, dchk, 1'b0, exp);
      if (exp == 3'h7) rd_f = 1'b1;
      chk(rctl, ctl);
    end
  endtask

  task write(input ctl, input dchk, input busy, input [2:0] exp);
    reg old;
    begin
      old = wctl;
      cmd({7'h28, ctl}, dchk, busy, exp);
      chk(wctl, old);
      @(posedge clk); #1 tx_start = 1'b1;
      @(posedge clk); #1 tx_start = 1'b0;
      repeat (4) @(posedge clk);
      #1 chk(wctl, (exp == 3'h7 || exp == 3'h1) ? ctl : old);
    end
  endtask

  task accept;
    begin
      @(posedge clk); #1 irq_accept = 1'b1;
      @(posedge clk); #1 irq_accept = 1'b0;
      @(posedge clk); #1 chk(irq_req, 1'b0);
      acc_f = 1'b1;
    end
  endtask

  task rx_char(input [7:0] d);
    reg [2:0] e;
    integer w;
    begin
      e = exp_cc(prev_cc, acc_f, rd_f);
      @(posedge clk); #1 go = 1'b1; tx_data = d;
      @(posedge clk); #1 go = 1'b0;
      @(posedge clk); #1 w = 0;
      while (snd_busy === 1'b1 && w < 12 * DIV) begin
        @(posedge clk); #1 w = w + 1;
      end
      chk(irq_req, 1'b1);
      chk(irq_cc, e);
      chk(rx_data, d);
      prev_cc = e; acc_f = 1'b0; rd_f = 1'b0;
    end
  endtask

  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == LIMIT) begin
      fails = fails + 1;
      test_done;
    end
  end

  initial begin
    {rst_b, sys_reset, dev_reset, irq_accept, cmd_strobe, data_check, tx_busy, tx_start, go} = 9'h000;
    rate_sel = 4'h0; cmd_byte = 8'h00; tx_data = 8'h00; fails = 0; n_tests = 0; cycles = 0;
    prev_cc = 3'h0; acc_f = 1'b1; rd_f = 1'b1;
    b = $urandom(11);
    repeat (8) @(posedge clk);
    #1 rst_b = 1'b1;
    repeat (3) @(posedge clk);
    #1 chk({rctl, wctl, irq_req, rx_active, cmd_ack}, 8'h00);
    for (i = 0; i < 3; i = i + 1) begin
      b = $urandom;
      rx_char(b);
      accept;
      read(b[0], 1'b0, 3'h7);
    end
    read(~rctl, 1'b0, 3'h1);
    read(~rctl, 1'b1, 3'h5);
    for (i = 0; i < 6; i = i + 1) begin
      b = (i == 0) ? 8'h13 : (i == 1) ? 8'h57 : $urandom;
      if (b[7:1] != 7'h08 && b[7:1] != 7'h28) begin
        c = rctl;
        cmd(b, 1'b0, 1'b0, 3'h3);
        chk(rctl, c);
      end
    end
    write(1'b1, 1'b0, 1'b0, 3'h7);
    write(1'b0, 1'b1, 1'b0, 3'h5);
    write(1'b0, 1'b0, 1'b1, 3'h1);
    rx_char($urandom);
    rx_char($urandom);
    accept;
    rx_char($urandom);
    rx_char($urandom);
    accept;
    read(1'b1, 1'b0, 3'h7);
    rx_char($urandom);
    rx_char($urandom);
    rx_char($urandom);
    accept;
    read(1'b0, 1'b0, 3'h7);
    rx_char($urandom);
    for (i = 0; i < 2; i = i + 1) begin
      read(1'b1, 1'b0, (i == 0) ? 3'h7 : 3'h1);
      write(1'b1, 1'b0, 1'b0, 3'h7);
      @(posedge clk); #1 {sys_reset, dev_reset} = (i == 0) ? 2'b10 : 2'b01;
      @(posedge clk); #1 {sys_reset, dev_reset} = 2'b00;
      chk({rctl, wctl}, 8'h00);
      prev_cc = 3'h0; acc_f = 1'b1; rd_f = 1'b1;
    end
    test_done;
  end
endmodule // tb_top

// [tb/ttyrs_asserts.sv]
// Purpose : Concurrent checks on receive status, command answers and switch outputs.
// Assumes : Bound to ttyrs_top; the receive span is judged at rate code 0 only.
// Notes   : Span counter keeps the length of the last character after it ends.
`timescale 1ns/100ps
module ttyrs_asserts #(
  parameter P_CLK_HZ = 20000000
) (
  // Clock and resets
  input wire       i_clk,
  input wire       i_rst_b,
  input wire       i_sys_reset,
  input wire       i_dev_reset,
  // Receive side
  input wire [3:0] i_rate_sel,
  input wire       i_irq_accept,
  input wire       o_irq_req,
  input wire [2:0] o_irq_cc,
  input wire       o_rx_active,
  // Commands and switches
  input wire       i_cmd_strobe,
  input wire [7:0] i_cmd_byte,
  input wire       i_tx_start,
  input wire       o_cmd_ack,
  input wire [2:0] o_cmd_cc,
  input wire       o_rctl_closed,
  input wire       o_wctl_closed
);
  localparam int SPAN = 9 * (P_CLK_HZ / 9600);
  reg [15:0] span_reg;
  reg        act_reg;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      span_reg <= 16'h0000;
      act_reg  <= 1'b0;
    end else begin
      act_reg <= o_rx_active;
      if (o_rx_active)
        span_reg <= act_reg ? span_reg + 16'h0001 : 16'h0001;
    end
  end

  sequence s_read_cmd;
    i_cmd_strobe && (i_cmd_byte[7:1] == 7'h08) && !i_sys_reset && !i_dev_reset;
  endsequence
  sequence s_reset_req;
    i_sys_reset || i_dev_reset;
  endsequence

  rx_span_a : assert property (
    $rose(o_irq_req) && (i_rate_sel == 4'h0) |-> !o_rx_active && (span_reg >= SPAN - 2) && (span_reg <= SPAN + 2))
    else $error("receive span to interrupt is wrong");
  irq_even_a : assert property (
    $rose(o_irq_req) |-> !o_irq_cc[0]) else $error("interrupt code is odd");
  irq_drop_a : assert property (
    o_irq_req && i_irq_accept && !o_rx_active |=> !o_irq_req) else $error("interrupt kept after accept");
  ack_next_a : assert property (
    i_cmd_strobe |=> o_cmd_ack && o_cmd_cc[0]) else $error("command answer missing or even");
  bad_cmd_a : assert property (
    i_cmd_strobe && (i_cmd_byte[7:1] != 7'h08) && (i_cmd_byte[7:1] != 7'h28) |=> o_cmd_cc == 3'h3)
    else $error("bad command not rejected");
  rctl_set_a : assert property (
    s_read_cmd |=> o_rctl_closed == $past(i_cmd_byte[0])) else $error("read switch not updated");
  rctl_hold_a : assert property (
    $changed(o_rctl_closed) |-> $past(i_cmd_strobe) || $past(i_sys_reset) || $past(i_dev_reset))
    else $error("read switch moved without cause");
  rst_open_a : assert property (
    s_reset_req |=> !o_rctl_closed && !o_wctl_closed) else $error("reset left a switch closed");
  wctl_win_a : assert property (
    $changed(o_wctl_closed) && !$past(i_sys_reset) && !$past(i_dev_reset) |->
      $past(i_tx_start) || $past(i_tx_start, 2) || $past(i_tx_start, 3) || $past(i_tx_start, 4))
    else $error("write switch moved outside start window");
endmodule // ttyrs_asserts

bind ttyrs_top ttyrs_asserts #(.P_CLK_HZ(P_CLK_HZ)) i_chk (
  .i_clk(i_clk), .i_rst_b(i_rst_b), .i_sys_reset(i_sys_reset), .i_dev_reset(i_dev_reset),
  .i_rate_sel(i_rate_sel), .i_irq_accept(i_irq_accept), .o_irq_req(o_irq_req), .o_irq_cc(o_irq_cc),
  .o_rx_active(o_rx_active), .i_cmd_strobe(i_cmd_strobe), .i_cmd_byte(i_cmd_byte), .i_tx_start(i_tx_start),
  .o_cmd_ack(o_cmd_ack), .o_cmd_cc(o_cmd_cc), .o_rctl_closed(o_rctl_closed), .o_wctl_closed(o_wctl_closed));

// [tb/ttyrs_tb_sender.sv]
// Purpose : Serial character source in place of the attached device.
// Assumes : Mark is logic one; the line moves 1 ns after a clock edge.
// Notes   : Always two stop bits, so successive characters keep the full gap.
`timescale 1ns/100ps
module ttyrs_tb_sender #(
  parameter P_DIV = 10
) (
  // Clock and request
  input  wire       i_clk,
  input  wire       i_go,
  input  wire [7:0] i_data,
  // Serial line
  output reg        o_line,
  output reg        o_busy
);
  reg [10:0] frame_reg;
  integer    k;

  initial begin
    o_line = 1'b1;
    o_busy = 1'b0;
    forever begin
      @(posedge i_clk);
      if (i_go === 1'b1) begin
        #1;
        o_busy    = 1'b1;
        frame_reg = {2'b11, i_data, 1'b0};
        for (k = 0; k < 11; k = k + 1) begin
          o_line = frame_reg[k];
          repeat (P_DIV) @(posedge i_clk);
          #1;
        end
        o_busy = 1'b0;
      end
    end
  end
endmodule // ttyrs_tb_sender
